// ### hw/tawc_top.v
/*
 * Trigger-driven acquisition sequencer, auto-wake source gating, shared
 * interrupt/trigger pin and an AXI4-Lite register slave.
 * Assumes the ADC takes one acquisition per acq_strobe pulse, change and
 * orientation events arrive as one-cycle pulses on this clock, and the
 * pin level is asynchronous.
 */
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "tawc_consts.vh"

module tawc_top (
    // Clock and reset
    input wire clock,
    input wire rst,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Shared interrupt / trigger pin
    input wire pin_in,
    output reg pin_out,
    output reg pin_oe,
    // Change detection and orientation events
    input wire evt_within_threshold,
    input wire evt_outside_threshold,
    input wire evt_orientation_change,
    // Acquisition and result strobes
    output reg acq_strobe,
    output reg result_to_out_regs,
    output reg result_to_buffer,
    // Wake control
    output reg wake_request,
    output reg sleep_block,
    // Interrupt
    output reg irq
);

    // ==========================================================
    // Register state
    reg [7:0] sensor_config_trigger_wake_q;
    reg [7:0] ctrl_q;
    reg [2:0] status_q;
    reg [2:0] mask_q;

    wire trigger_acquisition_mode = sensor_config_trigger_wake_q[`TAWC_CFG_TRIG_MODE];
    wire wake_on_within_threshold = sensor_config_trigger_wake_q[`TAWC_CFG_WAKE_WT];
    wire wake_on_outside_threshold = sensor_config_trigger_wake_q[`TAWC_CFG_WAKE_OT];
    wire wake_on_orientation_change = sensor_config_trigger_wake_q[`TAWC_CFG_WAKE_OR];
    wire pin_function_select = sensor_config_trigger_wake_q[`TAWC_CFG_PIN_FUNC];
    wire irq_driver_type = sensor_config_trigger_wake_q[`TAWC_CFG_DRV_OD];
    wire irq_polarity = sensor_config_trigger_wake_q[`TAWC_CFG_POL];
    wire [1:0] buf_mode = ctrl_q[`TAWC_CTRL_BUF_LO+1:`TAWC_CTRL_BUF_LO];
    wire low_power_mode = ctrl_q[`TAWC_CTRL_LOW_PWR];
    wire [3:0] dec_sel = ctrl_q[`TAWC_CTRL_DEC_LO+3:`TAWC_CTRL_DEC_LO];

    // ==========================================================
    // Decimation factor
    // Codes above the top step saturate at 4096
    reg [12:0] dec_factor;
    always @* begin
        if (low_power_mode) begin
            dec_factor = 13'h0001;
        end else if (dec_sel > `TAWC_DEC_MAX_SEL) begin
            dec_factor = 13'h1000;
        end else begin
            dec_factor = 13'h0001 << dec_sel;
        end
    end

    // ==========================================================
    // Trigger pin synchroniser and edge detect
    reg trig_s1_q;
    reg trig_s2_q;
    reg trig_s3_q;
    always @(posedge clock) begin
        if (rst) begin
            trig_s1_q <= 1'b0;
            trig_s2_q <= 1'b0;
            trig_s3_q <= 1'b0;
        end else begin
            trig_s1_q <= pin_in;
            trig_s2_q <= trig_s1_q;
            trig_s3_q <= trig_s2_q;
        end
    end
    // Only an input while the pin is configured as trigger
    wire trig_edge = pin_function_select & trig_s2_q & ~trig_s3_q;

    // ==========================================================
    // Acquisition sequencer
    localparam ST_IDLE = 1'b0;
    localparam ST_BURST = 1'b1;
    reg state_q;
    reg [12:0] acq_cnt_q;
    reg result_d;
    reg overrun_d;
    always @(posedge clock) begin
        if (rst) begin
            state_q <= ST_IDLE;
            acq_cnt_q <= 13'h0000;
            acq_strobe <= 1'b0;
            result_d <= 1'b0;
            overrun_d <= 1'b0;
        end else begin
            acq_strobe <= 1'b0;
            result_d <= 1'b0;
            overrun_d <= 1'b0;
            if (!pin_function_select) begin
                // Trigger mode ignored; drop partial decimation
                state_q <= ST_IDLE;
                acq_cnt_q <= 13'h0000;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (trig_edge && trigger_acquisition_mode) begin
                            // One edge starts a whole burst
                            state_q <= ST_BURST;
                            acq_cnt_q <= 13'h0000;
                        end else if (trig_edge) begin
                            acq_strobe <= 1'b1;
                            if (acq_cnt_q + 13'h0001 >= dec_factor) begin
                                acq_cnt_q <= 13'h0000;
                                result_d <= 1'b1;
                            end else begin
                                acq_cnt_q <= acq_cnt_q + 13'h0001;
                            end
                        end
                    end
                    ST_BURST: begin
                        acq_strobe <= 1'b1;
                        // Edges during a burst are lost, flagged as overrun
                        overrun_d <= trig_edge;
                        if (acq_cnt_q + 13'h0001 >= dec_factor) begin
                            acq_cnt_q <= 13'h0000;
                            state_q <= ST_IDLE;
                            result_d <= 1'b1;
                        end else begin
                            acq_cnt_q <= acq_cnt_q + 13'h0001;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                        acq_cnt_q <= 13'h0000;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Result routing and wake sources
    wire drdy_evt = result_d & (buf_mode == 2'b00);
    wire wake_evt = (wake_on_within_threshold & evt_within_threshold)
        | (wake_on_outside_threshold & evt_outside_threshold)
        | (wake_on_orientation_change & evt_orientation_change);
    always @(posedge clock) begin
        if (rst) begin
            result_to_out_regs <= 1'b0;
            result_to_buffer <= 1'b0;
            wake_request <= 1'b0;
            sleep_block <= 1'b0;
        end else begin
            result_to_out_regs <= result_d & (buf_mode == 2'b00);
            result_to_buffer <= result_d & (buf_mode != 2'b00);
            wake_request <= wake_evt;
            sleep_block <= wake_evt;
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
    wire rd_go = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
    wire wr_cfg = wr_go & (s_axi_awaddr == `TAWC_OFS_CFG) & s_axi_wstrb[0];
    wire wr_ctrl = wr_go & (s_axi_awaddr == `TAWC_OFS_CTRL) & s_axi_wstrb[0];
    wire wr_stat = wr_go & (s_axi_awaddr == `TAWC_OFS_STATUS) & s_axi_wstrb[0];
    wire wr_mask = wr_go & (s_axi_awaddr == `TAWC_OFS_MASK) & s_axi_wstrb[0];
    wire wr_hit = (s_axi_awaddr == `TAWC_OFS_CFG) | (s_axi_awaddr == `TAWC_OFS_CTRL)
        | (s_axi_awaddr == `TAWC_OFS_STATUS) | (s_axi_awaddr == `TAWC_OFS_MASK)
        | (s_axi_awaddr == `TAWC_OFS_STATE);
    wire [2:0] evt_set = {overrun_d, wake_evt, drdy_evt};

    always @(posedge clock) begin
        if (rst) begin
            sensor_config_trigger_wake_q <= `TAWC_CFG_RESET;
            ctrl_q <= `TAWC_CTRL_RESET;
            mask_q <= 3'h0;
            status_q <= `TAWC_ST_RESET;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TAWC_RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_cfg) begin
                sensor_config_trigger_wake_q <= s_axi_wdata[7:0];
            end
            if (wr_ctrl) begin
                ctrl_q <= s_axi_wdata[7:0];
            end
            if (wr_mask) begin
                mask_q <= s_axi_wdata[2:0];
            end
            // Set wins over a clear in the same cycle
            if (wr_stat) begin
                status_q <= (status_q & ~s_axi_wdata[2:0]) | evt_set;
            end else begin
                status_q <= status_q | evt_set;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `TAWC_RESP_OKAY : `TAWC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    reg [31:0] rd_val;
    reg rd_hit;
    always @* begin
        rd_val = 32'h00000000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `TAWC_OFS_CFG: rd_val = {24'h000000, sensor_config_trigger_wake_q};
            `TAWC_OFS_CTRL: rd_val = {24'h000000, ctrl_q};
            `TAWC_OFS_STATUS: rd_val = {29'h00000000, status_q};
            `TAWC_OFS_MASK: rd_val = {29'h00000000, mask_q};
            `TAWC_OFS_STATE: rd_val = {16'h0000, 2'h0, state_q, acq_cnt_q};
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge clock) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TAWC_RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_hit ? `TAWC_RESP_OKAY : `TAWC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Interrupt and shared pin drive
    wire irq_level = |(status_q & mask_q);
    wire pin_level = irq_polarity ? irq_level : ~irq_level;
    always @(posedge clock) begin
        if (rst) begin
            irq <= 1'b0;
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            irq <= irq_level;
            pin_out <= pin_level;
            if (pin_function_select) begin
                pin_oe <= 1'b0;
            end else if (irq_driver_type) begin
                // Open drain only pulls low
                pin_oe <= ~pin_level;
            end else begin
                pin_oe <= 1'b1;
            end
        end
    end

endmodule // tawc_top
`default_nettype wire

// ### hw/tawc_consts.vh
/*
 * Constants of the trigger and auto-wake configuration block: register
 * offsets, field positions, reset values. Assumes a 32-bit AXI4-Lite bus.
 */
// Functional notes
// - One 8-bit read/write register at byte 0x18 resets to 0x01 and holds trigger mode, wake enables, pulse, pin function, driver and polarity.
// - With trigger mode 0 every rising trigger edge makes one acquisition and a result follows once edges equal the decimation factor.
// - With trigger mode 1 a rising trigger edge outside a burst makes a burst of acquisitions as long as the decimation factor, then a result.
// - A finished result goes to the output registers or to the sample buffer as the buffer mode selects.
// - The trigger mode bit only counts while the shared pin is set up as the trigger input.
// - Data-ready rises only once every acquisition of one output is done and the result exists.
// - Data-ready rises only while the buffer mode is 00b.
// - In low-power mode the decimation factor is 1, so the trigger mode makes no difference.
// - With bit 6 set a within-threshold change event blocks sleep entry and forces wake; otherwise it is ignored.
// - With bit 5 set an outside-threshold change event blocks sleep entry and forces wake; otherwise it is ignored.
// - With the pin function bit set the shared pin is an undriven trigger input and interrupt routing to it is dropped.
// - With bit 4 set an orientation change blocks sleep entry and forces wake; otherwise it is ignored.
`ifndef TAWC_CONSTS_VH
`define TAWC_CONSTS_VH

// ==========================================================
// Register byte offsets
`define TAWC_OFS_CTRL 8'h00
`define TAWC_OFS_STATUS 8'h04
`define TAWC_OFS_MASK 8'h08
`define TAWC_OFS_STATE 8'h0C
`define TAWC_OFS_CFG 8'h18

// ==========================================================
// Configuration register fields and reset
`define TAWC_CFG_RESET 8'h01
`define TAWC_CFG_TRIG_MODE 7
`define TAWC_CFG_WAKE_WT 6
`define TAWC_CFG_WAKE_OT 5
`define TAWC_CFG_WAKE_OR 4
`define TAWC_CFG_RDY_PULSE 3
`define TAWC_CFG_PIN_FUNC 2
`define TAWC_CFG_DRV_OD 1
`define TAWC_CFG_POL 0

// ==========================================================
// Control register fields
`define TAWC_CTRL_RESET 8'h00
`define TAWC_CTRL_BUF_LO 0
`define TAWC_CTRL_LOW_PWR 2
`define TAWC_CTRL_DEC_LO 4
`define TAWC_DEC_MAX_SEL 4'hC

// ==========================================================
// Status bits (write one to clear)
`define TAWC_ST_DRDY 0
`define TAWC_ST_WAKE 1
`define TAWC_ST_OVR 2
`define TAWC_ST_RESET 3'h0

// ==========================================================
// Bus answers
`define TAWC_RESP_OKAY 2'h0
`define TAWC_RESP_SLVERR 2'h2

`endif

// ### sim/tawc_assertions.sv
/* Port checker of the trigger and auto-wake block.
   Assumes it is bound into tawc_top and shares its clock. */
`timescale 1ns/100ps
`default_nettype none

module tawc_assertions (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Pin and events
    input wire logic pin_oe,
    input wire logic evt_within_threshold,
    input wire logic evt_outside_threshold,
    input wire logic evt_orientation_change,
    // Results and wake
    input wire logic acq_strobe,
    input wire logic result_to_out_regs,
    input wire logic result_to_buffer,
    input wire logic wake_request,
    input wire logic sleep_block
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    wire any_evt = evt_within_threshold | evt_outside_threshold | evt_orientation_change;
    wire any_res = result_to_out_regs | result_to_buffer;

    property p_wr_ans; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
        |=> s_axi_awready && s_axi_wready && s_axi_bvalid; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
    property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_drop: assert property (p_b_drop) else $error("write answer stuck");
    property p_rd_ans; s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
        |=> s_axi_arready && s_axi_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    // A result may only follow the acquisition that completes it
    property p_res_acq; any_res |-> $past(acq_strobe); endproperty
    a_res_acq: assert property (p_res_acq) else $error("result without acquisition");
    property p_res_excl; !(result_to_out_regs && result_to_buffer); endproperty
    a_res_excl: assert property (p_res_excl) else $error("result sent twice");
    property p_trig_in; acq_strobe |-> !pin_oe; endproperty
    a_trig_in: assert property (p_trig_in) else $error("acquisition while pin driven");
    property p_wake_blk; wake_request == sleep_block; endproperty
    a_wake_blk: assert property (p_wake_blk) else $error("wake and block differ");
    property p_wake_cause; wake_request |-> $past(any_evt) || $past(any_evt, 2); endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wake without event");
endmodule // tawc_assertions

`default_nettype wire

// ### sim/tawc_host_model.sv
/* Host timer that drives trigger edges onto the shared pin.
   Assumes one clock shared with the block. */
`timescale 1ns/100ps
`default_nettype none

module tawc_host_model (
    // Clock
    input wire logic clock,
    // Trigger request
    input wire logic fire,
    input wire logic [3:0] hold,
    // Shared pin
    input wire logic pin_oe,
    input wire logic pin_out,
    output wire logic pin_in
);
    // ==========================================================
    // Trigger pulse
    logic lvl_q = 1'b0;
    logic [3:0] cnt_q = 4'h0;
    // High for hold plus one cycles, so both short and long pulses occur
    always @(posedge clock) begin
        if (fire) begin
            lvl_q <= 1'b1;
            cnt_q <= hold;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else begin
            lvl_q <= 1'b0;
        end
    end
    // Host level reaches the pin only while the block leaves it undriven
    assign pin_in = pin_oe ? pin_out : lvl_q;
endmodule // tawc_host_model

`default_nettype wire

// ### sim/tb_trigger_and_autowake_config.sv
/* Self-checking bench of tawc_top: bus master, trigger and wake tests.
   Assumes tawc_host_model and tawc_assertions. */
`timescale 1ns/100ps
`default_nettype none
`include "tawc_consts.vh"

module tb_trigger_and_autowake_config;
    // ==========================================================
    // Signals
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fire = 1'b0;
    logic evt_within_threshold = 1'b0, evt_outside_threshold = 1'b0;
    logic evt_orientation_change = 1'b0;
    logic [3:0] hold = 4'h2;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire pin_in, pin_out, pin_oe, acq_strobe, result_to_out_regs, result_to_buffer;
    wire wake_request, sleep_block, irq;
    logic [31:0] rv;
    logic [1:0] rsp;
    integer fails = 0, n_tests = 0, seed = 15941, rnd, i, j, w0;
    integer n_acq = 0, n_res = 0, n_buf = 0, n_wake = 0;

    tawc_top u_dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .evt_within_threshold,
        .evt_outside_threshold, .evt_orientation_change, .acq_strobe, .result_to_out_regs,
        .result_to_buffer, .wake_request, .sleep_block, .irq);
    tawc_host_model u_host (.clock, .fire, .hold, .pin_oe, .pin_out, .pin_in);

    always #20 clock = ~clock;
    always @(posedge clock) begin
        n_acq += acq_strobe;
        n_res += result_to_out_regs;
        n_buf += result_to_buffer;
        n_wake += wake_request;
    end

    // ==========================================================
    // Tasks
    task chk(input string nm, input [31:0] e, input [31:0] s);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        integer k;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            k++;
        end while (s_axi_bvalid !== 1'b1 && k < 40);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (k == 40) fails++;
        repeat (2) @(posedge clock);
    endtask
    task rd(input [7:0] a);
        integer k;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            k++;
        end while (s_axi_rvalid !== 1'b1 && k < 40);
        rv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (k == 40) fails++;
        @(posedge clock);
    endtask
    // ==========================================================
    // Expectations from the configuration
    function integer dec_of(input [7:0] ctl);
        if (ctl[`TAWC_CTRL_LOW_PWR]) dec_of = 1;
        else if (ctl[7:4] > `TAWC_DEC_MAX_SEL) dec_of = 4096;
        else dec_of = 1 << ctl[7:4];
    endfunction
    // Edges 17 cycles apart: a burst above 16 swallows the next edge
    function integer res_of(input [7:0] cfg, input [7:0] ctl, input integer n);
        if (!cfg[`TAWC_CFG_PIN_FUNC]) res_of = 0;
        else if (!cfg[`TAWC_CFG_TRIG_MODE]) res_of = n / dec_of(ctl);
        else if (dec_of(ctl) > 16) res_of = (n + 1) / 2;
        else res_of = n;
    endfunction
    function integer acq_of(input [7:0] cfg, input [7:0] ctl, input integer n);
        if (!cfg[`TAWC_CFG_PIN_FUNC]) acq_of = 0;
        else if (!cfg[`TAWC_CFG_TRIG_MODE]) acq_of = n;
        else acq_of = res_of(cfg, ctl, n) * dec_of(ctl);
    endfunction
    // Edges 17 cycles apart; bursts above 16 acquisitions overrun
    task edges(input integer n);
        repeat (n) begin
            rnd = {$random(seed)} % 4;
            fire <= 1'b1;
            hold <= 4'h2 + rnd[3:0];
            @(posedge clock);
            fire <= 1'b0;
            repeat (16) @(posedge clock);
        end
    endtask
    task scen(input [7:0] cfg, input [7:0] ctl, input integer n);
        integer a0, r0, b0, er, ov;
        er = res_of(cfg, ctl, n);
        ov = cfg[7] && cfg[2] && dec_of(ctl) > 16 && n > 1;
        wr(`TAWC_OFS_CFG, 32'h0);
        wr(`TAWC_OFS_CTRL, {24'h0, ctl});
        wr(`TAWC_OFS_CFG, {24'h0, cfg});
        chk("pin_oe", {31'h0, ~cfg[2]}, {31'h0, pin_oe});
        a0 = n_acq;
        r0 = n_res;
        b0 = n_buf;
        edges(n);
        // Let the last burst run out
        repeat (24) @(posedge clock);
        chk("acq", acq_of(cfg, ctl, n), n_acq - a0);
        chk("res", (ctl[1:0] == 2'h0) ? er : 0, n_res - r0);
        chk("buf", (ctl[1:0] != 2'h0) ? er : 0, n_buf - b0);
        rd(`TAWC_OFS_STATUS);
        chk("drdy", {31'h0, (ctl[1:0] == 2'h0) && (er > 0)}, {31'h0, rv[0]});
        chk("ovr", ov, {31'h0, rv[2]});
        wr(`TAWC_OFS_STATUS, 32'h7);
        $display("test cfg %h ctl %h done", cfg, ctl);
    endtask

    // ==========================================================
    // Sequence
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(`TAWC_OFS_CFG);
        chk("cfg_reset", 32'h1, rv);
        rnd = $random(seed);
        wr(`TAWC_OFS_CFG, {24'h0, rnd[7:0]});
        rd(`TAWC_OFS_CFG);
        chk("cfg_rw", {24'h0, rnd[7:0]}, rv);
        // Low byte strobe off: the write must not land
        s_axi_wstrb <= 4'hE;
        wr(`TAWC_OFS_CFG, 32'h0);
        s_axi_wstrb <= 4'hF;
        rd(`TAWC_OFS_CFG);
        chk("cfg_strb", {24'h0, rnd[7:0]}, rv);
        rd(8'h40);
        chk("unmapped", {30'h0, `TAWC_RESP_SLVERR}, {30'h0, rsp});
        wr(8'h40, 32'h0);
        chk("wr_unmapped", {30'h0, `TAWC_RESP_SLVERR}, {30'h0, rsp});
        $display("test registers done");
        scen(8'h05, 8'h00, 1);
        wr(`TAWC_OFS_MASK, 32'h1);
        edges(1);
        chk("irq_set", 1, {31'h0, irq});
        wr(`TAWC_OFS_MASK, 32'h0);
        chk("irq_mask", 0, {31'h0, irq});
        wr(`TAWC_OFS_MASK, 32'h1);
        wr(`TAWC_OFS_STATUS, 32'h1);
        chk("irq_clear", 0, {31'h0, irq});
        $display("test irq done");
        scen(8'h05, 8'h20, 4);
        scen(8'h85, 8'h20, 1);
        scen(8'h85, 8'h24, 1);
        scen(8'h85, 8'h21, 1);
        scen(8'h81, 8'h20, 2);
        scen(8'h85, 8'h50, 2);
        // Random mode, factor up to 8, low power, buffer mode and edge count
        for (i = 0; i < 4; i++) begin
            rnd = $random(seed);
            scen({rnd[0], 7'h05}, {2'h0, rnd[2:1], 1'b0, rnd[3], rnd[5:4]}, 1 + rnd[7:6]);
        end
        // Last pass enables no wake source, so nothing may wake
        for (i = 0; i < 4; i++) begin
            wr(`TAWC_OFS_CFG, 32'h1 | (32'h40 >> i));
            w0 = n_wake;
            for (j = 0; j < 3; j++) begin
                {evt_within_threshold, evt_outside_threshold, evt_orientation_change} <= 3'h4 >> j;
                @(posedge clock);
                {evt_within_threshold, evt_outside_threshold, evt_orientation_change} <= 3'h0;
                repeat (3) @(posedge clock);
            end
            chk("wake", (i < 3), n_wake - w0);
        end
        rd(`TAWC_OFS_STATUS);
        chk("wake_st", 32'h1, {31'h0, rv[1]});
        $display("test wake done");
        // Second reset in mid-run must restore the defaults
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(`TAWC_OFS_CFG);
        chk("cfg_rerst", 32'h1, rv);
        rd(`TAWC_OFS_STATUS);
        chk("st_rerst", 32'h0, rv);
        $display("test reset done");
        end_sim;
    end

    initial begin
        repeat (30000) @(posedge clock);
        fails++;
        end_sim;
    end
endmodule // tb_trigger_and_autowake_config

bind tawc_top tawc_assertions u_chk (.clock, .rst, .s_axi_awvalid, .s_axi_wvalid,
    .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .pin_oe, .evt_within_threshold, .evt_outside_threshold,
    .evt_orientation_change, .acq_strobe, .result_to_out_regs, .result_to_buffer,
    .wake_request, .sleep_block);

`default_nettype wire
